// *** core/dev_status_pkg.sv ***
// constants for the root port device error status register
// assumes a config-space access port carrying byte address and byte enables
package dev_status_pkg;
   localparam logic [7:0]  DEV_STATUS_OFFSET = 8'haa;
   localparam logic [15:0] DEV_STATUS_RESET  = 16'h0000;
   localparam int          BIT_CORR          = 0;
   localparam int          BIT_NONFATAL      = 1;
   localparam int          BIT_FATAL         = 2;
   localparam int          BIT_UNSUPP        = 3;
   localparam int          BIT_PENDING       = 5;
   localparam logic [15:0] FLAG_MASK         = 16'h000f;
endpackage

// *** core/sticky_flag.sv ***
// one write-one-to-clear sticky error flag
// assumes set and clear are single-cycle qualified strobes
`timescale 1ns/1ps
module sticky_flag (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   // set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clr_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule

// *** core/device_error_status.sv ***
// device error status register of a root port
// assumes cfg write/read strobes are one-cycle, byte address plus byte enables
`timescale 1ns/1ps
module device_error_status
   import dev_status_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cfg_wr_i,
   input  wire logic        cfg_rd_i,
   input  wire logic [7:0]  cfg_addr_i,
   input  wire logic [1:0]  cfg_be_i,
   input  wire logic [15:0] cfg_wdata_i,
   input  wire logic        pending_i,
   input  wire logic        unsupp_req_i,
   input  wire logic        unsupp_sev_fatal_i,
   input  wire logic        fatal_err_i,
   input  wire logic        nonfatal_err_i,
   input  wire logic        corr_err_i,
   input  wire logic        rx_err_msg_i,
   output logic [15:0]      cfg_rdata_o,
   output logic             cfg_rvalid_o,
   output logic [15:0]      device_error_status_o
);
   logic        hit;
   logic [3:0]  clr_mask;
   logic [3:0]  set_vec;
   logic [3:0]  flags;
   logic        pending_r;

   assign hit = (cfg_addr_i == DEV_STATUS_OFFSET);
   // low byte lane holds all writable bits; reserved bits ignore writes
   assign clr_mask = (cfg_wr_i && hit && cfg_be_i[0]) ?
                     (cfg_wdata_i[3:0] & FLAG_MASK[3:0]) : 4'h0;

   // reporting enables and advanced masks are deliberately not inputs here;
   // received messages (rx_err_msg_i) never reach the set terms
   always_comb begin
      set_vec               = 4'h0;
      set_vec[BIT_UNSUPP]   = unsupp_req_i;
      set_vec[BIT_FATAL]    = fatal_err_i
                              | (unsupp_req_i & unsupp_sev_fatal_i);
      set_vec[BIT_NONFATAL] = nonfatal_err_i
                              | (unsupp_req_i & ~unsupp_sev_fatal_i);
      set_vec[BIT_CORR]     = corr_err_i;
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_flag
         sticky_flag u_flag (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .set_i  (set_vec[g]),
            .clr_i  (clr_mask[g]),
            .flag_o (flags[g])
         );
      end
   endgenerate

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pending_r <= 1'b0;
      end else begin
         pending_r <= pending_i;
      end
   end

   always_comb begin
      device_error_status_o              = DEV_STATUS_RESET;
      device_error_status_o[3:0]         = flags;
      device_error_status_o[BIT_PENDING] = pending_r;
   end

   // unmapped reads answer zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_rdata_o  <= 16'h0000;
         cfg_rvalid_o <= 1'b0;
      end else begin
         cfg_rvalid_o <= cfg_rd_i;
         if (cfg_rd_i && hit) begin
            cfg_rdata_o <= device_error_status_o;
         end else begin
            cfg_rdata_o <= 16'h0000;
         end
      end
   end

   property p_unsupp_sets;
      @(posedge clk_i) disable iff (rst_i)
         unsupp_req_i |=> device_error_status_o[BIT_UNSUPP];
   endproperty
   a_unsupp_sets: assert property (p_unsupp_sets)
      else $error("unsupported request flag not set");

   property p_unsupp_sev;
      @(posedge clk_i) disable iff (rst_i)
         unsupp_req_i |=> ($past(unsupp_sev_fatal_i) ?
            device_error_status_o[BIT_FATAL] :
            device_error_status_o[BIT_NONFATAL]);
   endproperty
   a_unsupp_sev: assert property (p_unsupp_sev)
      else $error("severity flag missing after unsupported request");

   property p_fatal_sets;
      @(posedge clk_i) disable iff (rst_i)
         fatal_err_i |=> device_error_status_o[BIT_FATAL];
   endproperty
   a_fatal_sets: assert property (p_fatal_sets)
      else $error("fatal flag not set");

   property p_nonfatal_sets;
      @(posedge clk_i) disable iff (rst_i)
         nonfatal_err_i |=> device_error_status_o[BIT_NONFATAL];
   endproperty
   a_nonfatal_sets: assert property (p_nonfatal_sets)
      else $error("non-fatal flag not set");

   property p_corr_sets;
      @(posedge clk_i) disable iff (rst_i)
         corr_err_i |=> device_error_status_o[BIT_CORR];
   endproperty
   a_corr_sets: assert property (p_corr_sets)
      else $error("correctable flag not set");

   property p_msg_no_set;
      @(posedge clk_i) disable iff (rst_i)
         (rx_err_msg_i && !unsupp_req_i && !fatal_err_i && !nonfatal_err_i
            && !corr_err_i && (device_error_status_o[3:0] == 4'h0))
         |=> (device_error_status_o[3:0] == 4'h0);
   endproperty
   a_msg_no_set: assert property (p_msg_no_set)
      else $error("received message set a flag");

   property p_pending;
      @(posedge clk_i) disable iff (rst_i)
         ##1 device_error_status_o[BIT_PENDING] == $past(pending_i);
   endproperty
   a_pending: assert property (p_pending)
      else $error("pending bit does not track transactions");

   property p_reserved;
      @(posedge clk_i) disable iff (rst_i)
         (device_error_status_o[15:6] == 10'h000)
         && !device_error_status_o[4] && !cfg_rdata_o[4];
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bit nonzero");

   property p_clear;
      @(posedge clk_i) disable iff (rst_i)
         (clr_mask[BIT_FATAL] && !set_vec[BIT_FATAL])
         |=> !device_error_status_o[BIT_FATAL];
   endproperty
   a_clear: assert property (p_clear)
      else $error("fatal flag not cleared by write one");

   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
         (device_error_status_o[BIT_CORR] && !clr_mask[BIT_CORR])
         |=> device_error_status_o[BIT_CORR];
   endproperty
   a_hold: assert property (p_hold)
      else $error("correctable flag dropped without clear");

   // read data must show the view as it stood in the read cycle
   property p_read_hit;
      @(posedge clk_i) disable iff (rst_i)
         (cfg_rd_i && hit)
         |=> (cfg_rdata_o == $past(device_error_status_o));
   endproperty
   a_read_hit: assert property (p_read_hit)
      else $error("read data differs from status");

   property p_read_miss;
      @(posedge clk_i) disable iff (rst_i)
         !(cfg_rd_i && hit) |=> (cfg_rdata_o == 16'h0000);
   endproperty
   a_read_miss: assert property (p_read_miss)
      else $error("read data not zero without a hit");

   property p_rvalid;
      @(posedge clk_i) disable iff (rst_i)
         ##1 cfg_rvalid_o == $past(cfg_rd_i);
   endproperty
   a_rvalid: assert property (p_rvalid)
      else $error("read valid does not follow the read strobe");

   property p_unsupp_only_event;
      @(posedge clk_i) disable iff (rst_i)
         (!unsupp_req_i && !device_error_status_o[BIT_UNSUPP])
         |=> !device_error_status_o[BIT_UNSUPP];
   endproperty
   a_unsupp_only_event: assert property (p_unsupp_only_event)
      else $error("unsupported flag set with no request");

   property p_fatal_only_event;
      @(posedge clk_i) disable iff (rst_i)
         (!fatal_err_i && !(unsupp_req_i && unsupp_sev_fatal_i)
            && !device_error_status_o[BIT_FATAL])
         |=> !device_error_status_o[BIT_FATAL];
   endproperty
   a_fatal_only_event: assert property (p_fatal_only_event)
      else $error("fatal flag set with no fatal error");

   property p_nonfatal_only_event;
      @(posedge clk_i) disable iff (rst_i)
         (!nonfatal_err_i && !(unsupp_req_i && !unsupp_sev_fatal_i)
            && !device_error_status_o[BIT_NONFATAL])
         |=> !device_error_status_o[BIT_NONFATAL];
   endproperty
   a_nonfatal_only_event: assert property (p_nonfatal_only_event)
      else $error("non-fatal flag set with no non-fatal error");

   // clears checked from the bus pins so a broken clear decode shows up
   property p_clear_corr;
      @(posedge clk_i) disable iff (rst_i)
         (cfg_wr_i && hit && cfg_be_i[0] && cfg_wdata_i[BIT_CORR]
            && !corr_err_i)
         |=> !device_error_status_o[BIT_CORR];
   endproperty
   a_clear_corr: assert property (p_clear_corr)
      else $error("correctable flag not cleared by write one");

   property p_clear_unsupp;
      @(posedge clk_i) disable iff (rst_i)
         (cfg_wr_i && hit && cfg_be_i[0] && cfg_wdata_i[BIT_UNSUPP]
            && !unsupp_req_i)
         |=> !device_error_status_o[BIT_UNSUPP];
   endproperty
   a_clear_unsupp: assert property (p_clear_unsupp)
      else $error("unsupported flag not cleared by write one");

   property p_keep_flags;
      @(posedge clk_i) disable iff (rst_i)
         !(cfg_wr_i && hit && cfg_be_i[0])
         |=> (($past(device_error_status_o[3:0])
               & ~device_error_status_o[3:0]) == 4'h0);
   endproperty
   a_keep_flags: assert property (p_keep_flags)
      else $error("flag fell without a write-one clear");
endmodule

// *** test/err_source.sv ***
// link-side source of port error events and the pending level
// assumes the bench hands it one random word per cycle
`timescale 1ns/1ps
module err_source (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [15:0] rnd_i,
   output logic             pending_o,
   output logic [4:0]       err_o,
   output logic             msg_o
);
   // error and pending bits anded in pairs or threes so events stay sparse and flags can stay clear; msg_o is one raw bit
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pending_o <= 1'b0;
         err_o     <= 5'h00;
         msg_o     <= 1'b0;
      end else begin
         pending_o <= rnd_i[14] & rnd_i[13];
         err_o     <= rnd_i[4:0] & rnd_i[9:5] & {1'b1, rnd_i[12:9]};
         msg_o     <= rnd_i[15];
      end
   end
endmodule

// *** test/device_error_status_tb.sv ***
// self-checking bench: random config traffic and error events
// assumes the design's live view and read port are registered
`timescale 1ns/1ps
module device_error_status_tb;
   import dev_status_pkg::*;
   logic        clk_i = 0, rst_i = 1, cfg_wr_i = 0, cfg_rd_i = 0, quiet = 0;
   logic [7:0]  cfg_addr_i = 8'h00;
   logic [1:0]  cfg_be_i = 2'h0;
   logic [15:0] cfg_wdata_i = 16'h0000, rnd = 16'h0000;
   logic [15:0] rdata, status, exp = 16'h0000, exp_rd = 16'h0000;
   logic        rvalid, exp_rv = 0, pend, msg;
   logic [4:0]  err;
   logic [31:0] r;
   integer      seed = 32'h0456, fail_count = 0, total_checks = 0, cyc = 0;
   always #10 clk_i = ~clk_i;
   err_source u_err_source (.clk_i(clk_i), .rst_i(rst_i), .rnd_i(rnd),
      .pending_o(pend), .err_o(err), .msg_o(msg));
   device_error_status u_device_error_status (.clk_i(clk_i), .rst_i(rst_i),
      .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
      .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .pending_i(pend),
      .unsupp_req_i(err[3]), .unsupp_sev_fatal_i(err[4]),
      .fatal_err_i(err[2]), .nonfatal_err_i(err[1]), .corr_err_i(err[0]),
      .rx_err_msg_i(msg), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
      .device_error_status_o(status));
   // set wins over a same-cycle clear; the message input never counts
   function automatic logic [15:0] next_status(input logic [15:0] cur);
      logic [3:0] set, clr;
      set = {err[3], err[2] | (err[3] & err[4]),
             err[1] | (err[3] & ~err[4]), err[0]};
      clr = (cfg_wr_i && cfg_addr_i == DEV_STATUS_OFFSET && cfg_be_i[0]) ?
            cfg_wdata_i[3:0] : 4'h0;
      return {10'h000, pend, 1'b0, set | (cur[3:0] & ~clr)};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      total_checks = total_checks + 1;
      if (got !== want) begin
         fail_count = fail_count + 1;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic chk_bit(input logic got, input logic want);
      total_checks = total_checks + 1;
      if (got !== want) begin
         fail_count = fail_count + 1;
         $display("[FAIL] %0t valid got %b want %b", $time, got, want);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ten reset cycles, 4000 random and a few corner cycles, plus margin
   localparam int LIMIT = 6000;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fail_count = fail_count + 1;
         $display("[FAIL] %0t timeout", $time);
         test_done;
      end
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         exp <= DEV_STATUS_RESET;
         exp_rd <= 16'h0000;
         exp_rv <= 1'b0;
      end else begin
         exp <= next_status(exp);
         exp_rd <= (cfg_rd_i && cfg_addr_i == DEV_STATUS_OFFSET) ?
                   exp : 16'h0000;
         exp_rv <= cfg_rd_i;
      end
   end
   always @(negedge clk_i) begin
      chk(status, exp);
      chk(rdata, exp_rd);
      chk_bit(rvalid, exp_rv);
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4000) @(posedge clk_i) begin
         r = $random(seed);
         cfg_wr_i <= r[0] & r[1];
         cfg_rd_i <= r[2];
         cfg_addr_i <= r[3] ? DEV_STATUS_OFFSET : r[15:8];
         cfg_be_i <= r[5:4];
         cfg_wdata_i <= {12'h000, r[19:16]};
         // once quiet, messages still arrive but no errors do
         rnd <= quiet ? {r[31], 15'h0000} : 16'($random(seed));
         if (cyc == 3000) quiet <= 1'b1;
      end
      $display("random and quiet-clear test done");
      // corner: a fatal event and its write-one clear land on one edge
      @(posedge clk_i);
      cfg_wr_i    <= 1'b0;
      cfg_rd_i    <= 1'b0;
      rnd         <= 16'h0884; // only the fatal bit survives the ands
      @(posedge clk_i);
      rnd         <= 16'h0000;
      cfg_wr_i    <= 1'b1;
      cfg_rd_i    <= 1'b1;
      cfg_addr_i  <= DEV_STATUS_OFFSET;
      cfg_be_i    <= 2'h1;
      cfg_wdata_i <= 16'h0004;
      @(posedge clk_i);
      cfg_rd_i    <= 1'b0;
      @(posedge clk_i);
      cfg_wr_i    <= 1'b0;
      cfg_rd_i    <= 1'b1;
      @(posedge clk_i);
      cfg_rd_i    <= 1'b0;
      repeat (2) @(posedge clk_i);
      $display("set-clear collision test done");
      test_done;
   end
endmodule
